/* File: sar_adc_sequencer_tb.sv */
// Self-checking testbench for the converter sequencer
`include "sas_map.svh"
module sar_adc_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sas_pkg::*;
	// ==========================================
	// Stimulus and observation signals
	logic        i_clk_sys  = 1'b0;
	logic        i_rst      = 1'b1;
	logic        i_ce       = 1'b1;
	int          phi_n      = 0;
	logic        i_trig_pin = 1'b1;
	logic [9:0]  i_adc_data = 10'h000;
	sas_wb_req_t wb_req     = '0;
	logic [31:0] o_wb_dat;
	logic        o_wb_ack;
	logic        o_done_irq;
	sas_ana_t    o_ana;
	logic [31:0] rd;
	int          err_total  = 0;
	int          n_tests    = 0;
	int          n;

	// Source clock, 50 ns period
	always #25 i_clk_sys = ~i_clk_sys;

	// Running count of conversion clock pulses seen on the analog side
	always @(negedge i_clk_sys) begin
		phi_n <= phi_n + ((o_ana.phi === 1'b1) ? 1 : 0);
	end

	sas_sequencer dut (
		.i_clk_sys  (i_clk_sys),
		.i_rst      (i_rst),
		.i_ce       (i_ce),
		.i_wb       (wb_req),
		.o_wb_dat   (o_wb_dat),
		.o_wb_ack   (o_wb_ack),
		.i_trig_pin (i_trig_pin),
		.i_adc_data (i_adc_data),
		.o_ana      (o_ana),
		.o_done_irq (o_done_irq)
	);

	// ==========================================
	// Verdict and comparisons
	task summarize;
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk

	task chk_rng(input string nm, input int lo, input int hi, input int got);
		n_tests++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask : chk_rng

	// ==========================================
	// Wishbone classic single cycle, held until ack sampled high
	task xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		input logic [3:0] sel);
		@(posedge i_clk_sys);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, dat: dat, sel: sel};
		do @(posedge i_clk_sys); while (o_wb_ack !== 1'b1);
		rd = o_wb_dat;
		wb_req <= '0;
	endtask : xfer

	task wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h000000, d}, 4'hF);
	endtask : wr

	task rdr(input logic [7:0] a);
		xfer(1'b0, a, 32'h00000000, 4'hF);
	endtask : rdr

	// Counts falling edges until the completion pulse; 0 if none seen
	task wait_irq(input int lim, output int cnt);
		int k;
		cnt = 0;
		for (k = 1; k <= lim; k++) begin
			@(negedge i_clk_sys);
			if (o_done_irq === 1'b1) begin
				cnt = k;
				break;
			end
		end
	endtask : wait_irq

	// One-shot software conversion with expected length worked out here
	task conv(input logic [2:0] cks, input logic sh, input logic r10, input logic [1:0] grp,
		input logic [2:0] ch, input logic [1:0] ext, input logic [2:0] idx, input logic [9:0] d);
		int dv;
		int ln;
		int c;
		int p0;
		case (cks)
			3'h0: dv = 4;
			3'h1: dv = 2;
			3'h2, 3'h3: dv = 1;
			3'h4: dv = 12;
			3'h5: dv = 6;
			default: dv = 3;
		endcase
		ln = sh ? (r10 ? 33 : 28) : (r10 ? 59 : 49);
		i_adc_data <= d;
		wr(`SAS_OFF_CTL1, {2'h0, 1'b1, cks[1], r10, 1'b0, ext});
		wr(`SAS_OFF_CTL2, {3'h0, cks[2], 1'b0, grp, sh});
		p0 = phi_n;
		wr(`SAS_OFF_CTL0, {cks[0], 1'b1, 1'b0, 2'h0, ch});
		repeat (2) @(negedge i_clk_sys);
		chk("analog_ctl", {21'h0, 1'b1, grp, ch, ext, sh, r10, 1'b1}, {21'h0, o_ana[11:1]});
		wait_irq(2000, c);
		chk_rng("conv_cycles", dv * ln - 1, dv * ln + 3, c + 2);
		rdr(`SAS_OFF_CTL0);
		chk("start_clear", 32'h0, {31'h0, rd[6]});
		chk("phi_count", 32'(ln), 32'(phi_n - p0));
		rdr(`SAS_OFF_RES0 + {3'h0, idx, 2'h0});
		chk("result", r10 ? {22'h0, d} : {24'h0, d[7:0]}, rd);
	endtask : conv

	// ==========================================
	// Main sequence
	initial begin
		repeat (16) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		rdr(`SAS_OFF_CTL0);
		chk("ctl0_reset", 32'h0, rd);
		rdr(`SAS_OFF_CTL2);
		chk("ctl2_reset", 32'h0, rd);
		rdr(`SAS_OFF_STAT);
		chk("status_idle", 32'h1, {30'h0, rd[1:0]});
		chk("ref_off", 32'h0, {31'h0, o_ana.ref_on});
		// Unmapped and byte-lane-disabled writes are ignored
		wr(8'h14, 8'hFF);
		rdr(8'h14);
		chk("unmapped", 32'h0, rd);
		xfer(1'b1, `SAS_OFF_CTL2, 32'h000000FF, 4'hE);
		rdr(`SAS_OFF_CTL2);
		chk("sel_off", 32'h0, rd);
		// Connect reference and settle over 1 us
		wr(`SAS_OFF_CTL1, 8'h20);
		repeat (25) @(posedge i_clk_sys);
		chk("ref_on", 32'h1, {31'h0, o_ana.ref_on});
		// Every divider code, both resolutions, with and without hold
		conv(3'h0, 1'b0, 1'b0, 2'h0, 3'h5, 2'h0, 3'h5, 10'h3A5);
		conv(3'h1, 1'b0, 1'b1, 2'h1, 3'h2, 2'h0, 3'h2, 10'h2C3);
		conv(3'h2, 1'b1, 1'b0, 2'h2, 3'h7, 2'h0, 3'h7, 10'h155);
		conv(3'h3, 1'b1, 1'b1, 2'h0, 3'h0, 2'h0, 3'h0, 10'h3FF);
		conv(3'h4, 1'b0, 1'b0, 2'h1, 3'h3, 2'h1, 3'h0, 10'h1E7);
		conv(3'h5, 1'b1, 1'b1, 2'h2, 3'h6, 2'h2, 3'h1, 10'h26B);
		conv(3'h6, 1'b0, 1'b1, 2'h0, 3'h4, 2'h0, 3'h4, 10'h0D8);
		conv(3'h7, 1'b1, 1'b0, 2'h1, 3'h1, 2'h0, 3'h1, 10'h377);
		// Repeat mode at /3, 28 cycles: no request, results refresh
		i_adc_data <= 10'h111;
		wr(`SAS_OFF_CTL0, 8'h08);
		wr(`SAS_OFF_CTL0, 8'h4A);
		wait_irq(300, n);
		chk_rng("repeat_irq", 0, 0, n);
		rdr(`SAS_OFF_RES0 + 8'h08);
		chk("repeat_res", 32'h11, rd);
		i_adc_data <= 10'h0AA;
		repeat (200) @(posedge i_clk_sys);
		rdr(`SAS_OFF_RES0 + 8'h08);
		chk("repeat_again", 32'hAA, rd);
		rdr(`SAS_OFF_STAT);
		chk("status_run", 32'h2, {30'h0, rd[1:0]});
		wr(`SAS_OFF_CTL0, 8'h0A);
		repeat (3) @(posedge i_clk_sys);
		rdr(`SAS_OFF_STAT);
		chk("halt_idle", 32'h1, {30'h0, rd[1:0]});
		// One-shot halted mid-run: no result, no request
		i_adc_data <= 10'h2F0;
		wr(`SAS_OFF_CTL0, 8'h03);
		wr(`SAS_OFF_CTL0, 8'h43);
		repeat (30) @(posedge i_clk_sys);
		wr(`SAS_OFF_CTL0, 8'h03);
		wait_irq(150, n);
		chk_rng("halt_irq", 0, 0, n);
		rdr(`SAS_OFF_RES0 + 8'h0C);
		chk("halt_res", 32'h0, rd);
		// External trigger: waits for a fall, a second fall restarts
		i_adc_data <= 10'h0C3;
		wr(`SAS_OFF_CTL0, 8'h64);
		wait_irq(100, n);
		chk_rng("no_edge_irq", 0, 0, n);
		@(posedge i_clk_sys);
		i_trig_pin <= 1'b0;
		repeat (40) @(posedge i_clk_sys);
		i_trig_pin <= 1'b1;
		repeat (10) @(posedge i_clk_sys);
		i_trig_pin <= 1'b0;
		// Freeze for 20 cycles mid-conversion: completion moves out by as much
		repeat (10) @(posedge i_clk_sys);
		i_ce <= 1'b0;
		repeat (20) @(posedge i_clk_sys);
		i_ce <= 1'b1;
		wait_irq(300, n);
		chk_rng("retrigger", 74, 80, n);
		rdr(`SAS_OFF_RES0 + 8'h10);
		chk("ext_res", 32'hC3, rd);
		wr(`SAS_OFF_CTL0, 8'h00);
		wr(`SAS_OFF_CTL1, 8'h00);
		repeat (3) @(posedge i_clk_sys);
		chk("ref_cut", 32'h0, {31'h0, o_ana.ref_on});
		summarize();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge i_clk_sys);
		err_total++;
		summarize();
	end
endmodule : sar_adc_sequencer_tb

/* File: sas_map.svh */
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH
// ==========================================
// Register byte offsets
`define SAS_OFF_CTL0    8'h00
`define SAS_OFF_CTL1    8'h04
`define SAS_OFF_CTL2    8'h08
`define SAS_OFF_STAT    8'h0C
`define SAS_OFF_RES0    8'h20
`define SAS_OFF_RESN    8'h3C
// ==========================================
// Control zero fields
`define SAS_C0_CH_LO    0
`define SAS_C0_MD_LO    3
`define SAS_C0_TRG      5
`define SAS_C0_START    6
`define SAS_C0_CLOCK_DIV_SEL0     7
// Control one fields
`define SAS_C1_EXT_LO   0
`define SAS_C1_RES10    3
`define SAS_C1_CLOCK_DIV_SEL1     4
`define SAS_C1_REF      5
// Control two fields
`define SAS_C2_SH       0
`define SAS_C2_GRP_LO   1
`define SAS_C2_CLOCK_DIV_SEL2     4
// ==========================================
// Reset values
`define SAS_RST_CTL0    8'h00
`define SAS_RST_CTL1    8'h00
`define SAS_RST_CTL2    8'h00
// ==========================================
// Conversion lengths in conversion clock cycles
`define SAS_LEN8_NOSH   6'd49
`define SAS_LEN10_NOSH  6'd59
`define SAS_LEN8_SH     6'd28
`define SAS_LEN10_SH    6'd33
// Source clock divisors
`define SAS_DIV1        4'd1
`define SAS_DIV2        4'd2
`define SAS_DIV3        4'd3
`define SAS_DIV4        4'd4
`define SAS_DIV6        4'd6
`define SAS_DIV12       4'd12
`endif

/* File: sas_pkg.sv */
// Types shared by the converter sequencer
package sas_pkg;
	// Sequencer states, one-hot
	typedef enum logic [1:0] {
		SAS_ST_IDLE = 2'b01,
		SAS_ST_RUN  = 2'b10
	} sas_state_t;
	// Operating modes
	typedef enum logic [1:0] {
		SAS_MD_ONESHOT = 2'b00,
		SAS_MD_REPEAT  = 2'b01
	} sas_mode_t;
	// Classic Wishbone request
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [31:0] dat;
		logic [3:0]  sel;
	} sas_wb_req_t;
	// Controls toward the analog core
	typedef struct packed {
		logic       ref_on;
		logic [1:0] group;
		logic [2:0] chan;
		logic [1:0] ext;
		logic       sh_en;
		logic       res10;
		logic       run;
		logic       phi;
	} sas_ana_t;
endpackage : sas_pkg

/* File: sas_sequencer.sv */
// Converter sequencer: triggers, conversion clock, lengths, modes and result registers
// What this block does
// RULE_01 - Trigger select 0: conversion starts as soon as the start bit is set.
// RULE_02 - Trigger select 1: each falling trigger-pin edge after start bit set (re)starts.
// RULE_03 - Without sample-and-hold: 49 clocks at 8 bits, 59 at 10 bits.
// RULE_04 - With sample-and-hold: 28 clocks at 8 bits, 33 at 10 bits.
// RULE_05 - Divider codes: 000 /4, 001 /2, 010 /1, 100 /12, 101 /6, 110 /3.
// RULE_06 - Code 011 gives undivided clock, code 111 divides by three.
// RULE_07 - Software keeps conversion clock within 250 kHz or 1 MHz up to 10 MHz.
// RULE_08 - Resolution of 8 or 10 bits selectable in every mode.
// RULE_09 - Channel i of any group lands in result register i.
// RULE_10 - Channel, group and extended select pick exactly one input.
// RULE_11 - One-shot converts once and raises the completion request.
// RULE_12 - One-shot with software trigger clears the start bit at completion.
// RULE_13 - Repeat mode converts continuously without requests until start bit clears.
// RULE_14 - Writing start bit 0 halts a running conversion.
// RULE_15 - Software does not rewrite control registers during a conversion.
// RULE_16 - After a mode change software rewrites channel select separately.
// RULE_17 - Reference connect 0 disconnects the reference from the ladder.
// RULE_18 - Software waits 1 us after connecting reference before starting.
// RULE_19 - Results occupy bits 0 to 9 at 10 bits, 0 to 7 at 8 bits.
// RULE_20 - Extended inputs zero and one land in result registers 0 and 1.
//
// Decided for this implementation: the address map and register access over Wishbone.
module sas_sequencer (
	input  wire logic                i_clk_sys,
	input  wire logic                i_rst,
	input  wire logic                i_ce,
	input  wire sas_pkg::sas_wb_req_t i_wb,
	output logic [31:0]              o_wb_dat,
	output logic                     o_wb_ack,
	input  wire logic                i_trig_pin,
	input  wire logic [9:0]          i_adc_data,
	output sas_pkg::sas_ana_t        o_ana,
	output logic                     o_done_irq
);
	import sas_pkg::*;
`include "sas_map.svh"

	// ==========================================
	// Helpers
	// Divider code to divisor
	function automatic logic [3:0] div_ratio(input logic [2:0] cks);
		case (cks)
			3'b000: div_ratio = `SAS_DIV4;
			3'b001: div_ratio = `SAS_DIV2;
			3'b100: div_ratio = `SAS_DIV12;
			3'b101: div_ratio = `SAS_DIV6;
			3'b110: div_ratio = `SAS_DIV3;
			3'b111: div_ratio = `SAS_DIV3;
			default: div_ratio = `SAS_DIV1;
		endcase
	endfunction : div_ratio

	// Conversion length in conversion clock cycles
	function automatic logic [5:0] conv_len(input logic sh, input logic r10);
		if (sh) begin
			conv_len = r10 ? `SAS_LEN10_SH : `SAS_LEN8_SH;
		end else begin
			conv_len = r10 ? `SAS_LEN10_NOSH : `SAS_LEN8_NOSH;
		end
	endfunction : conv_len

	// ==========================================
	// Declarations
	logic [7:0]  ctl0_ff, ctl1_ff, ctl2_ff;
	logic [9:0]  res_ff [0:7];
	logic        ack_ff;
	logic [31:0] rdat_ff;
	logic        sync1_ff, sync2_ff, pin_d_ff;
	logic        seen_ff;
	sas_state_t  st_ff;
	logic [3:0]  div_ff;
	logic [5:0]  phi_cnt_ff;
	logic        irq_ff;
	sas_ana_t    ana_ff;
	logic        acc, wr_en, wr_c0, fall, trigger_select, start, rpt;
	logic        tick, last, go_idle, retrig, idle;
	logic [2:0]  cks;
	logic [3:0]  ratio;
	logic [5:0]  len;
	logic [2:0]  res_idx;
	logic [9:0]  res_val;
	logic [31:0] nxt_rdat;

	// Decode of control fields
	assign trigger_select   = ctl0_ff[`SAS_C0_TRG];
	assign start = ctl0_ff[`SAS_C0_START];
	assign rpt   = ctl0_ff[`SAS_C0_MD_LO +: 2] == SAS_MD_REPEAT;
	assign cks   = {ctl2_ff[`SAS_C2_CLOCK_DIV_SEL2], ctl1_ff[`SAS_C1_CLOCK_DIV_SEL1], ctl0_ff[`SAS_C0_CLOCK_DIV_SEL0]};
	assign ratio = div_ratio(cks); // [RULE_05] [RULE_06]
	assign len   = conv_len(ctl2_ff[`SAS_C2_SH], ctl1_ff[`SAS_C1_RES10]); // [RULE_03] [RULE_04]
	assign idle  = st_ff == SAS_ST_IDLE;

	// ==========================================
	// Wishbone slave, one wait state
	assign acc   = i_wb.cyc & i_wb.stb & ~ack_ff;
	assign wr_en = acc & i_wb.we & i_wb.sel[0] & i_ce;
	assign wr_c0 = wr_en & (i_wb.adr == `SAS_OFF_CTL0);

	// Read mux, unmapped reads as zero
	always_comb begin
		nxt_rdat = 32'h0000_0000;
		if (i_wb.adr == `SAS_OFF_CTL0) begin
			nxt_rdat[7:0] = ctl0_ff;
		end else if (i_wb.adr == `SAS_OFF_CTL1) begin
			nxt_rdat[7:0] = ctl1_ff;
		end else if (i_wb.adr == `SAS_OFF_CTL2) begin
			nxt_rdat[7:0] = ctl2_ff;
		end else if (i_wb.adr == `SAS_OFF_STAT) begin
			nxt_rdat[2:0] = {seen_ff, st_ff};
		end else if (i_wb.adr >= `SAS_OFF_RES0 && i_wb.adr <= `SAS_OFF_RESN
			&& i_wb.adr[1:0] == 2'b00) begin
			nxt_rdat[9:0] = res_ff[i_wb.adr[4:2]];
		end
	end

	// Acknowledge and read data
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end else if (i_ce) begin
			ack_ff  <= acc;
			rdat_ff <= nxt_rdat;
		end
	end
	assign o_wb_ack = ack_ff;
	assign o_wb_dat = rdat_ff;

	// ==========================================
	// Control registers; software write wins over the auto clear
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ctl0_ff <= `SAS_RST_CTL0;
			ctl1_ff <= `SAS_RST_CTL1;
			ctl2_ff <= `SAS_RST_CTL2;
		end else if (i_ce) begin
			if (wr_c0) begin
				ctl0_ff <= i_wb.dat[7:0]; // [RULE_14]
			end else if (last && !rpt && !trigger_select) begin
				ctl0_ff[`SAS_C0_START] <= 1'b0; // [RULE_12]
			end
			if (wr_en && i_wb.adr == `SAS_OFF_CTL1) begin
				ctl1_ff <= i_wb.dat[7:0];
			end
			if (wr_en && i_wb.adr == `SAS_OFF_CTL2) begin
				ctl2_ff <= i_wb.dat[7:0];
			end
		end
	end

	// ==========================================
	// Trigger pin synchroniser and falling edge
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			pin_d_ff <= 1'b1;
		end else if (i_ce) begin
			sync1_ff <= i_trig_pin;
			sync2_ff <= sync1_ff;
			pin_d_ff <= sync2_ff;
		end
	end
	assign fall   = pin_d_ff & ~sync2_ff & start & trigger_select; // [RULE_02]
	assign retrig = fall & ~idle;

	// Trigger seen since start bit set; lets repeat mode keep going
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			seen_ff <= 1'b0;
		end else if (i_ce) begin
			if (!start) begin
				seen_ff <= 1'b0;
			end else if (fall) begin
				seen_ff <= 1'b1;
			end
		end
	end

	// ==========================================
	// Sequencer state
	assign tick    = (div_ff == ratio - 4'd1) && !idle;
	assign last    = tick && (phi_cnt_ff == len - 6'd1) && start && !retrig;
	assign go_idle = start && (!trigger_select || fall || (rpt && seen_ff)); // [RULE_01] [RULE_13]

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			st_ff <= SAS_ST_IDLE;
		end else if (i_ce) begin
			case (st_ff)
				SAS_ST_IDLE: begin
					if (go_idle) begin
						st_ff <= SAS_ST_RUN;
					end
				end
				SAS_ST_RUN: begin
					if (!start || last) begin
						st_ff <= SAS_ST_IDLE; // [RULE_14] [RULE_11]
					end
				end
				default: begin
					st_ff <= SAS_ST_IDLE;
				end
			endcase
		end
	end

	// Source clock divider and conversion clock count
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			div_ff     <= 4'h0;
			phi_cnt_ff <= 6'h00;
		end else if (i_ce) begin
			if (idle || retrig) begin
				div_ff     <= 4'h0; // [RULE_02]
				phi_cnt_ff <= 6'h00;
			end else if (tick) begin
				div_ff     <= 4'h0; // [RULE_05]
				phi_cnt_ff <= phi_cnt_ff + 6'h01; // [RULE_03] [RULE_04]
			end else begin
				div_ff <= div_ff + 4'h1;
			end
		end
	end

	// ==========================================
	// Result placement
	always_comb begin
		res_idx = ctl0_ff[`SAS_C0_CH_LO +: 3]; // [RULE_09]
		if (ctl1_ff[`SAS_C1_EXT_LO +: 2] == 2'b01) begin
			res_idx = 3'h0; // [RULE_20]
		end else if (ctl1_ff[`SAS_C1_EXT_LO +: 2] == 2'b10) begin
			res_idx = 3'h1; // [RULE_20]
		end
		res_val = i_adc_data;
		if (!ctl1_ff[`SAS_C1_RES10]) begin
			res_val[9:8] = 2'b00; // [RULE_19] [RULE_08]
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			for (int i = 0; i < 8; i++) begin
				res_ff[i] <= 10'h000;
			end
		end else if (i_ce && last) begin
			res_ff[res_idx] <= res_val;
		end
	end

	// Completion request, one-shot only
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			irq_ff <= 1'b0;
		end else if (i_ce) begin
			irq_ff <= last && !rpt; // [RULE_11] [RULE_13]
		end
	end
	assign o_done_irq = irq_ff;

	// ==========================================
	// Controls toward the analog core
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ana_ff <= '0;
		end else if (i_ce) begin
			ana_ff.ref_on <= ctl1_ff[`SAS_C1_REF]; // [RULE_17]
			ana_ff.group  <= ctl2_ff[`SAS_C2_GRP_LO +: 2]; // [RULE_10]
			ana_ff.chan   <= ctl0_ff[`SAS_C0_CH_LO +: 3];
			ana_ff.ext    <= ctl1_ff[`SAS_C1_EXT_LO +: 2];
			ana_ff.sh_en  <= ctl2_ff[`SAS_C2_SH];
			ana_ff.res10  <= ctl1_ff[`SAS_C1_RES10]; // [RULE_08]
			ana_ff.run    <= !idle;
			ana_ff.phi    <= tick;
		end
	end
	assign o_ana = ana_ff;

	// ==========================================
	// Checks
	logic [9:0] cyc_ff;
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || idle || retrig) begin
			cyc_ff <= 10'h000;
		end else if (i_ce) begin
			cyc_ff <= cyc_ff + 10'h001;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	sequence s_sw_go;
		i_ce && idle && start && !trigger_select;
	endsequence

	property p_sw_start;
		s_sw_go |=> st_ff == SAS_ST_RUN && phi_cnt_ff == 6'h00;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("software start missed"); // [RULE_01]

	property p_ext_start;
		i_ce && fall |=> st_ff == SAS_ST_RUN && div_ff == 4'h0 && phi_cnt_ff == 6'h00;
	endproperty
	a_ext_start: assert property (p_ext_start) else $error("trigger edge missed"); // [RULE_02]

	property p_len_nosh;
		i_ce && last && !ctl2_ff[`SAS_C2_SH]
			|-> 32'(cyc_ff) + 1 == (ctl1_ff[`SAS_C1_RES10] ? 59 : 49) * 32'(ratio);
	endproperty
	a_len_nosh: assert property (p_len_nosh) else $error("bad length without hold"); // [RULE_03]

	property p_len_sh;
		i_ce && last && ctl2_ff[`SAS_C2_SH]
			|-> 32'(cyc_ff) + 1 == (ctl1_ff[`SAS_C1_RES10] ? 33 : 28) * 32'(ratio);
	endproperty
	a_len_sh: assert property (p_len_sh) else $error("bad length with hold"); // [RULE_04]

	property p_div_12;
		cks == 3'b100 |-> ratio == 4'd12;
	endproperty
	a_div_12: assert property (p_div_12) else $error("divide by 12 wrong"); // [RULE_05]

	property p_odd_codes;
		(cks == 3'b011 |-> ratio == 4'd1) and (cks == 3'b111 |-> ratio == 4'd3);
	endproperty
	a_odd_codes: assert property (p_odd_codes) else $error("odd divider code wrong"); // [RULE_06]

	property p_once_irq;
		i_ce && last && !rpt |=> o_done_irq ##1 !o_done_irq;
	endproperty
	a_once_irq: assert property (p_once_irq) else $error("completion request wrong"); // [RULE_11]

	property p_auto_clear;
		i_ce && last && !rpt && !trigger_select && !wr_c0 |=> !start && idle;
	endproperty
	a_auto_clear: assert property (p_auto_clear) else $error("start bit not cleared"); // [RULE_12]

	property p_rpt_quiet;
		i_ce && last && rpt |=> !o_done_irq;
	endproperty
	a_rpt_quiet: assert property (p_rpt_quiet) else $error("repeat raised request"); // [RULE_13]

	property p_halt;
		i_ce && !start |=> idle;
	endproperty
	a_halt: assert property (p_halt) else $error("halt not taken"); // [RULE_14]

	property p_ref_off;
		i_ce && !ctl1_ff[`SAS_C1_REF] |=> !o_ana.ref_on;
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("reference left on"); // [RULE_17]

	property p_res8;
		i_ce && last && !ctl1_ff[`SAS_C1_RES10] |=> res_ff[$past(res_idx)][9:8] == 2'b00;
	endproperty
	a_res8: assert property (p_res8) else $error("8-bit result too wide"); // [RULE_19]

	property p_ext0;
		i_ce && last && ctl1_ff[`SAS_C1_EXT_LO +: 2] == 2'b01 |=> res_ff[0] == $past(res_val);
	endproperty
	a_ext0: assert property (p_ext0) else $error("extended input zero misplaced"); // [RULE_20]
endmodule : sas_sequencer
